// ==== wdg_pkg.sv ====
package wdg_pkg;

	// register indices; byte address is four times the index
	localparam logic [9:0] CTRL_IDX = 10'h0c9;
	localparam logic [9:0] IRQ_IDX = 10'h0ca;
	localparam logic [9:0] STAT_IDX = 10'h0cb;

	// control register field positions
	localparam int CLR_POS = 4;
	localparam int MODE_POS = 2;
	localparam int INT_POS = 0;

	// irq register field positions
	localparam int IRQ_FLAG_POS = 0;
	localparam int IRQ_EN_POS = 1;

	// status register field positions
	localparam int STAT_BITE_POS = 0;
	localparam int STAT_ARM_POS = 1;

	// reset values
	localparam logic [1:0] INT_RST = 2'h0;
	localparam logic IRQ_EN_RST = 1'h0;

	// mode field codes
	localparam logic [1:0] MODE_IDLE = 2'h0;
	localparam logic [1:0] MODE_RSVD = 2'h1;
	localparam logic [1:0] MODE_WATCH = 2'h2;
	localparam logic [1:0] MODE_TIMER = 2'h3;

	// two-step clear keys
	localparam logic [3:0] KEY_FIRST = 4'ha;
	localparam logic [3:0] KEY_SECOND = 4'h5;

	// interval codes and their last count before the terminal event
	localparam logic [1:0] INT_32768 = 2'h0;
	localparam logic [1:0] INT_8192 = 2'h1;
	localparam logic [1:0] INT_512 = 2'h2;
	localparam logic [1:0] INT_64 = 2'h3;
	localparam logic [14:0] LAST_32768 = 15'h7fff;
	localparam logic [14:0] LAST_8192 = 15'h1fff;
	localparam logic [14:0] LAST_512 = 15'h01ff;
	localparam logic [14:0] LAST_64 = 15'h003f;

	// least counter width that holds the longest interval
	localparam int CNT_W_MIN = 15;

	// unit state, one-hot
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WATCH = 3'b010,
		ST_TIMER = 3'b100
	} wdg_state_type;

endpackage

// ==== wdg_tick_sync.sv ====
`timescale 1ns/1ps
// brings the slow clock pin into hclk and marks each rising edge
module wdg_tick_sync (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic lf_clk_in,
	output logic tick
);

	logic meta_r; // first stage, read only by sync_r
	logic sync_r; // second stage
	logic last_r; // previous synchronised level

	// two-flop synchroniser and edge memory
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			last_r <= 1'b0;
		end else if (ce) begin
			meta_r <= lf_clk_in;
			sync_r <= meta_r;
			last_r <= sync_r;
		end
	end

	// one-cycle pulse per slow clock period
	assign tick = ce & sync_r & ~last_r;

endmodule

// ==== wdg_top.sv ====
`timescale 1ns/1ps
module wdg_top #(
	parameter int CNT_W = 15
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic lf_clk_in,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic sys_reset_req,
	output logic wdog_irq
);

	// refuse a counter too narrow for the longest interval
	if (CNT_W < wdg_pkg::CNT_W_MIN) begin : g_bad_width
		$error("counter width too small");
	end

	// true when a stored word index selects the given register
	function automatic logic reg_hit(input logic [9:0] idx,
		input logic [9:0] reg_idx);
		reg_hit = (idx == reg_idx);
	endfunction

	// last count before the terminal event for an interval code
	function automatic logic [CNT_W-1:0] last_cnt(input logic [1:0] code);
		logic [14:0] v;
		v = wdg_pkg::LAST_32768;
		case (code)
			wdg_pkg::INT_8192: v = wdg_pkg::LAST_8192;
			wdg_pkg::INT_512: v = wdg_pkg::LAST_512;
			wdg_pkg::INT_64: v = wdg_pkg::LAST_64;
			default: v = wdg_pkg::LAST_32768;
		endcase
		last_cnt = CNT_W'(v);
	endfunction

	logic tick; // one pulse per slow clock rising edge
	logic dp_valid_r; // a data phase is under way
	logic dp_write_r; // that data phase writes
	logic [9:0] dp_idx_r; // word index of that data phase
	logic hreadyout_r; // always ready, no wait states
	logic hresp_r; // always okay
	logic [31:0] hrdata_r; // read data for the data phase
	wdg_pkg::wdg_state_type state_r; // idle, watchdog or timer
	wdg_pkg::wdg_state_type state_nxt;
	logic [CNT_W-1:0] cnt_r; // interval counter, not readable
	logic [CNT_W-1:0] cnt_nxt;
	logic [1:0] intv_r; // interval code
	logic [1:0] intv_nxt;
	logic armed_r; // first key seen, waiting for second
	logic tick_seen_r; // one slow edge passed since arming
	logic bite_r; // sticky system reset request
	logic irq_flag_r; // sticky timer interrupt flag
	logic irq_en_r; // interrupt enable
	logic irq_r; // gated interrupt request
	logic ap_take; // address phase accepted this cycle
	logic wr_ctrl; // control register written now
	logic wr_irq; // irq register written now
	logic [3:0] w_clr; // written clear key
	logic [1:0] w_mode; // written mode code
	logic [1:0] w_int; // written interval code
	logic term; // slow edge at the last count
	logic kick; // completed clear sequence
	logic [31:0] rd_word; // read mux output

	// slow clock pin crossing
	wdg_tick_sync u_tick (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.lf_clk_in(lf_clk_in),
		.tick(tick)
	);

	assign ap_take = hsel & htrans[1] & hready;
	assign wr_ctrl = ce & dp_valid_r & dp_write_r &
		reg_hit(dp_idx_r, wdg_pkg::CTRL_IDX);
	assign wr_irq = ce & dp_valid_r & dp_write_r &
		reg_hit(dp_idx_r, wdg_pkg::IRQ_IDX);
	assign w_clr = hwdata[wdg_pkg::CLR_POS +: 4];
	assign w_mode = hwdata[wdg_pkg::MODE_POS +: 2];
	assign w_int = hwdata[wdg_pkg::INT_POS +: 2];
	assign term = tick & (cnt_r == last_cnt(intv_r));
	assign kick = wr_ctrl & (state_r == wdg_pkg::ST_WATCH) & armed_r &
		(w_clr == wdg_pkg::KEY_SECOND);

	// address phase capture for the following data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_valid_r <= 1'b0;
			dp_write_r <= 1'b0;
			dp_idx_r <= 10'h000;
		end else if (ce) begin
			dp_valid_r <= ap_take;
			dp_write_r <= hwrite;
			dp_idx_r <= haddr[11:2];
		end
	end

	// read mux; clear keys and the counter read as zero
	always_comb begin
		rd_word = 32'h0000_0000;
		if (reg_hit(haddr[11:2], wdg_pkg::CTRL_IDX)) begin
			case (state_r)
				wdg_pkg::ST_WATCH: rd_word[wdg_pkg::MODE_POS +: 2] =
					wdg_pkg::MODE_WATCH;
				wdg_pkg::ST_TIMER: rd_word[wdg_pkg::MODE_POS +: 2] =
					wdg_pkg::MODE_TIMER;
				default: rd_word[wdg_pkg::MODE_POS +: 2] = wdg_pkg::MODE_IDLE;
			endcase
			rd_word[wdg_pkg::INT_POS +: 2] = intv_r;
		end else if (reg_hit(haddr[11:2], wdg_pkg::IRQ_IDX)) begin
			rd_word[wdg_pkg::IRQ_FLAG_POS] = irq_flag_r;
			rd_word[wdg_pkg::IRQ_EN_POS] = irq_en_r;
		end else if (reg_hit(haddr[11:2], wdg_pkg::STAT_IDX)) begin
			rd_word[wdg_pkg::STAT_BITE_POS] = bite_r;
			rd_word[wdg_pkg::STAT_ARM_POS] = armed_r;
		end
	end

	// bus answer: zero wait states, okay, unmapped reads give zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout_r <= 1'b1;
			hresp_r <= 1'b0;
			hrdata_r <= 32'h0000_0000;
		end else if (ce) begin
			hreadyout_r <= 1'b1;
			hresp_r <= 1'b0;
			if (ap_take && !hwrite) begin
				hrdata_r <= rd_word;
			end
		end
	end

	// mode, interval and counter next values
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		intv_nxt = intv_r;
		// counting runs only outside idle; terminal wraps to zero
		if (tick && state_r != wdg_pkg::ST_IDLE) begin
			cnt_nxt = term ? '0 : cnt_r + 1'b1;
		end
		case (state_r)
			wdg_pkg::ST_IDLE: begin
				// clear keys have no effect here
				if (wr_ctrl) begin
					intv_nxt = w_int;
					if (w_mode == wdg_pkg::MODE_WATCH) begin
						state_nxt = wdg_pkg::ST_WATCH;
						cnt_nxt = '0;
					end else if (w_mode == wdg_pkg::MODE_TIMER) begin
						state_nxt = wdg_pkg::ST_TIMER;
						cnt_nxt = '0;
					end
				end
			end
			wdg_pkg::ST_WATCH: begin
				// mode and interval locked; only the key pair acts
				if (kick) begin
					cnt_nxt = '0;
				end
			end
			wdg_pkg::ST_TIMER: begin
				// mode 10 and 01 ignored here: stop first
				if (wr_ctrl) begin
					if (w_mode == wdg_pkg::MODE_IDLE) begin
						state_nxt = wdg_pkg::ST_IDLE;
						cnt_nxt = '0;
					end else if (w_clr[0]) begin
						cnt_nxt = '0;
					end
				end
			end
			default: begin
				state_nxt = wdg_pkg::ST_IDLE;
				cnt_nxt = '0;
			end
		endcase
	end

	// mode state; watchdog has no way out but reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= wdg_pkg::ST_IDLE;
		end else if (ce) begin
			state_r <= state_nxt;
		end
	end

	// counter; no low-power clear, so value survives sleep
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r <= '0;
		end else if (ce) begin
			cnt_r <= cnt_nxt;
		end
	end

	// interval code, written only while idle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			intv_r <= wdg_pkg::INT_RST;
		end else if (ce) begin
			intv_r <= intv_nxt;
		end
	end

	// first key arms; arm lapses on the second slow edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			armed_r <= 1'b0;
			tick_seen_r <= 1'b0;
		end else if (ce) begin
			if (wr_ctrl && state_r == wdg_pkg::ST_WATCH) begin
				armed_r <= (w_clr == wdg_pkg::KEY_FIRST);
				tick_seen_r <= 1'b0;
			end else if (tick && armed_r) begin
				if (tick_seen_r) begin
					armed_r <= 1'b0;
				end
				tick_seen_r <= 1'b1;
			end
		end
	end

	// watchdog bite; a kick in the same cycle saves it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bite_r <= 1'b0;
		end else if (ce) begin
			if (state_r == wdg_pkg::ST_WATCH && term && !kick) begin
				bite_r <= 1'b1;
			end
		end
	end

	// timer flag: set beats a write-one clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_flag_r <= 1'b0;
			irq_en_r <= wdg_pkg::IRQ_EN_RST;
		end else if (ce) begin
			if (state_r == wdg_pkg::ST_TIMER && term) begin
				irq_flag_r <= 1'b1;
			end else if (wr_irq && hwdata[wdg_pkg::IRQ_FLAG_POS]) begin
				irq_flag_r <= 1'b0;
			end
			if (wr_irq) begin
				irq_en_r <= hwdata[wdg_pkg::IRQ_EN_POS];
			end
		end
	end

	// gated interrupt request
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_r <= 1'b0;
		end else if (ce) begin
			irq_r <= irq_flag_r & irq_en_r;
		end
	end

	assign hrdata = hrdata_r;
	assign hreadyout = hreadyout_r;
	assign hresp = hresp_r;
	assign sys_reset_req = bite_r;
	assign wdog_irq = irq_r;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// software start writes
	sequence s_start_watch;
		wr_ctrl && state_r == wdg_pkg::ST_IDLE &&
			w_mode == wdg_pkg::MODE_WATCH;
	endsequence
	sequence s_start_timer;
		wr_ctrl && state_r == wdg_pkg::ST_IDLE &&
			w_mode == wdg_pkg::MODE_TIMER;
	endsequence
	// second key while armed
	sequence s_kick_hit;
		wr_ctrl && state_r == wdg_pkg::ST_WATCH && armed_r &&
			w_clr == wdg_pkg::KEY_SECOND;
	endsequence

	a_idle_quiet: assert property (
		state_r == wdg_pkg::ST_IDLE |-> cnt_r == '0 && !bite_r)
		else $error("idle unit holds count or reset");
	a_watch_start: assert property (
		s_start_watch |=> state_r == wdg_pkg::ST_WATCH && cnt_r == '0)
		else $error("watchdog start failed");
	a_timer_start: assert property (
		s_start_timer |=> state_r == wdg_pkg::ST_TIMER && cnt_r == '0)
		else $error("timer start failed");
	a_watch_locked: assert property (
		state_r == wdg_pkg::ST_WATCH |=> state_r == wdg_pkg::ST_WATCH)
		else $error("watchdog left its mode");
	a_intv_frozen: assert property (
		state_r != wdg_pkg::ST_IDLE |=> $stable(intv_r))
		else $error("interval changed while running");
	a_count_step: assert property (
		ce && tick && !term && state_r != wdg_pkg::ST_IDLE && !wr_ctrl
		|=> cnt_r == $past(cnt_r) + 1'b1)
		else $error("counter did not advance by one");
	a_kick_clears: assert property (
		s_kick_hit |=> cnt_r == '0 && !armed_r)
		else $error("clear sequence did not zero counter");
	a_watch_bite: assert property (
		ce && state_r == wdg_pkg::ST_WATCH && term && !kick
		|=> bite_r ##1 sys_reset_req)
		else $error("missing reset request at terminal");
	a_bite_cause: assert property (
		$rose(bite_r) |-> $past(state_r) == wdg_pkg::ST_WATCH)
		else $error("reset request outside watchdog");
	a_flag_cause: assert property (
		$rose(irq_flag_r) |-> $past(state_r) == wdg_pkg::ST_TIMER)
		else $error("flag raised outside timer");
	a_timer_wrap: assert property (
		ce && state_r == wdg_pkg::ST_TIMER && term && !wr_ctrl
		|=> cnt_r == '0 && irq_flag_r)
		else $error("timer did not wrap with flag");
	a_timer_stop: assert property (
		wr_ctrl && state_r == wdg_pkg::ST_TIMER &&
		w_mode == wdg_pkg::MODE_IDLE
		|=> state_r == wdg_pkg::ST_IDLE && cnt_r == '0)
		else $error("timer stop failed");

endmodule

// ==== wdg_top_tb.sv ====
`timescale 1ns/1ps
// self-checking bench: drives the ahb port and the slow clock pin directly
module wdg_top_tb;
	// byte addresses of the three registers and an unmapped word
	localparam logic [31:0] ctrl_a = {20'h0, wdg_pkg::CTRL_IDX, 2'h0};
	localparam logic [31:0] irq_a = {20'h0, wdg_pkg::IRQ_IDX, 2'h0};
	localparam logic [31:0] stat_a = {20'h0, wdg_pkg::STAT_IDX, 2'h0};
	localparam logic [31:0] bad_a = 32'h0000_0010;
	logic hclk, hresetn, hsel, hwrite, lf_clk_in;
	logic ce; // clock enable, lowered to model a frozen power mode
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata;
	logic hreadyout, hresp, sys_reset_req, wdog_irq;
	int err_count, checks_done;

	// hready is the single slave's hreadyout; ce driven by the bench
	wdg_top dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .lf_clk_in(lf_clk_in),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.sys_reset_req(sys_reset_req), .wdog_irq(wdog_irq));

	// free-running 100 mhz clock
	initial hclk = 1'b0;
	always #5 hclk = ~hclk;

	// prints the counts and the verdict, then ends the run
	task automatic give_verdict;
		$display("mismatches %0d, comparisons %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// compares one 32-bit result
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string msg);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	// bounded wait for hready sampled high at a rising edge
	task automatic wait_rdy;
		int i;
		i = 0;
		do begin
			@(posedge hclk);
			i++;
		end while (hreadyout !== 1'b1 && i < 50);
		if (i >= 50) begin
			err_count++;
			$display("unexpected at %0t: bus stalled", $time);
			give_verdict();
		end
	endtask

	// single word write: address phase, then data phase
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= 1'b1;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
	endtask

	// single word read compared under a mask, response must be okay
	task automatic rd(input logic [31:0] a, input logic [31:0] m,
		input logic [31:0] exp, input string msg);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= 1'b0;
		wait_rdy();
		htrans <= 2'h0;
		wait_rdy();
		chk(hrdata & m, exp, msg);
		chk({31'h0, hresp}, 32'h0, "hresp");
	endtask

	// n slow clock periods, three hclk cycles high and three low
	task automatic ticks(input int n);
		repeat (n) begin
			lf_clk_in <= 1'b1;
			repeat (3) @(posedge hclk);
			lf_clk_in <= 1'b0;
			repeat (3) @(posedge hclk);
		end
	endtask

	// reset values and an unmapped address
	task automatic test_reset;
		chk({31'h0, sys_reset_req}, 32'h0, "rst req");
		rd(ctrl_a, 32'hff, 32'h0, "ctrl reset");
		rd(irq_a, 32'h3, 32'h0, "irq reset");
		rd(stat_a, 32'h1, 32'h0, "stat reset");
		rd(bad_a, 32'hffff_ffff, 32'h0, "unmapped");
		ticks(70);
		rd(irq_a, 32'h1, 32'h0, "idle no flag");
	endtask

	// exact terminal count and restart for one interval code
	task automatic test_timer(input logic [1:0] code, input int n);
		wr(ctrl_a, {28'h0, wdg_pkg::MODE_TIMER, code});
		ticks(n - 1);
		rd(irq_a, 32'h1, 32'h0, "flag early");
		ticks(1);
		rd(irq_a, 32'h1, 32'h1, "flag at count");
		chk({31'h0, sys_reset_req}, 32'h0, "timer no reset");
		wr(irq_a, 32'h1);
		ticks(n - 1);
		rd(irq_a, 32'h1, 32'h0, "flag early again");
		ticks(1);
		rd(irq_a, 32'h1, 32'h1, "flag recurs");
		wr(irq_a, 32'h1);
		wr(ctrl_a, 32'h0);
	endtask

	// one long interval, early and exact edge of the terminal count
	task automatic test_long;
		wr(ctrl_a, {28'h0, wdg_pkg::MODE_TIMER, wdg_pkg::INT_8192});
		ticks(8191);
		rd(irq_a, 32'h1, 32'h0, "long early");
		ticks(1);
		rd(irq_a, 32'h1, 32'h1, "long at count");
		wr(irq_a, 32'h1);
		wr(ctrl_a, 32'h0);
	endtask

	// frozen clock enable keeps the count; counting resumes after it
	task automatic test_retain;
		wr(ctrl_a, {28'h0, wdg_pkg::MODE_TIMER, wdg_pkg::INT_64});
		ticks(30);
		ce <= 1'b0;
		ticks(40);
		ce <= 1'b1;
		rd(irq_a, 32'h1, 32'h0, "frozen no flag");
		ticks(33);
		rd(irq_a, 32'h1, 32'h0, "resumed early");
		ticks(1);
		rd(irq_a, 32'h1, 32'h1, "resumed count");
		wr(irq_a, 32'h1);
		wr(ctrl_a, 32'h0);
	endtask

	// locks, clear bit, gated interrupt and stop in timer mode
	task automatic test_timer_ctl;
		wr(irq_a, 32'h2);
		wr(ctrl_a, 32'h0f);
		rd(ctrl_a, 32'hff, 32'h0f, "timer start");
		wr(ctrl_a, 32'h0c);
		rd(ctrl_a, 32'hff, 32'h0f, "interval locked");
		wr(ctrl_a, 32'h0b);
		rd(ctrl_a, 32'hff, 32'h0f, "no direct watchdog");
		ticks(40);
		wr(ctrl_a, 32'h1f);
		ticks(63);
		chk({31'h0, wdog_irq}, 32'h0, "cleared count");
		ticks(1);
		repeat (2) @(posedge hclk);
		chk({31'h0, wdog_irq}, 32'h1, "irq raised");
		wr(irq_a, 32'h3);
		repeat (2) @(posedge hclk);
		chk({31'h0, wdog_irq}, 32'h0, "irq cleared");
		ticks(30);
		wr(ctrl_a, 32'h03);
		rd(ctrl_a, 32'hff, 32'h03, "timer stopped");
		wr(ctrl_a, 32'h13);
		rd(ctrl_a, 32'hff, 32'h03, "idle clear");
		ticks(70);
		rd(irq_a, 32'h1, 32'h0, "stopped no flag");
		wr(irq_a, 32'h0);
	endtask

	// watchdog locks, key sequence and bite
	task automatic test_watchdog;
		wr(ctrl_a, 32'h0b);
		rd(ctrl_a, 32'hff, 32'h0b, "watchdog start");
		wr(ctrl_a, 32'h03);
		wr(ctrl_a, 32'h07);
		rd(ctrl_a, 32'hff, 32'h0b, "cannot disable");
		wr(ctrl_a, 32'h0f);
		rd(ctrl_a, 32'hff, 32'h0b, "no timer");
		wr(ctrl_a, 32'h08);
		rd(ctrl_a, 32'hff, 32'h0b, "interval locked");
		ticks(50);
		wr(ctrl_a, 32'hab);
		rd(stat_a, 32'h2, 32'h2, "armed");
		wr(ctrl_a, 32'h5b);
		ticks(10);
		wr(ctrl_a, 32'hab);
		ticks(2);
		rd(stat_a, 32'h2, 32'h0, "arm lapsed");
		wr(ctrl_a, 32'h5b);
		ticks(51);
		chk({31'h0, sys_reset_req}, 32'h0, "kick cleared");
		rd(irq_a, 32'h1, 32'h0, "no irq");
		ticks(1);
		repeat (2) @(posedge hclk);
		chk({31'h0, sys_reset_req}, 32'h1, "bite");
		rd(stat_a, 32'h1, 32'h1, "stat bite");
	endtask

	// a second reset clears the request and frees the mode again
	task automatic test_rereset;
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk({31'h0, sys_reset_req}, 32'h0, "req cleared");
		rd(ctrl_a, 32'hff, 32'h0, "idle again");
		wr(ctrl_a, 32'h0f);
		rd(ctrl_a, 32'hff, 32'h0f, "timer after reset");
	endtask

	// main sequence
	initial begin
		err_count = 0;
		checks_done = 0;
		hresetn = 1'b0;
		ce = 1'b1;
		hsel = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		lf_clk_in = 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		test_reset();
		test_timer(wdg_pkg::INT_64, 64);
		test_timer(wdg_pkg::INT_512, 512);
		test_long();
		test_retain();
		test_timer_ctl();
		test_watchdog();
		test_rereset();
		give_verdict();
	end
endmodule
